// >>> common/tone_monitor_regs.vh
// Behaviour
// - tone detection runs only while enabled
// - low-pass filter removes small tones from receive
// - overload flag sets above 1.1 V peak
// - tone flag sets on supply sag
// - tone flag selects 800 ohm dc termination
// - dc termination restores over about one second
// - both flags sticky until host writes zero
// - line stays off-hook during tone events
// - monitor enable alone selects higher-current converter
// - mode plus enable selects lower-power converter
// - gain field attenuates lower-power converter input
// - monitor samples ring inputs, sends over link
// - ring flags follow positive and negative thresholds
`ifndef TONE_MONITOR_REGS_VH
`define TONE_MONITOR_REGS_VH

// register offsets
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_SAMPLE     8'h08
`define ADDR_RXDATA     8'h0C

// control register fields
`define CTRL_TDE        0
`define CTRL_LME        1
`define CTRL_MODE       2
`define CTRL_RCR        3
`define CTRL_FWE        4
`define CTRL_OFFHOOK    5
`define CTRL_GAIN_LO    8
`define CTRL_GAIN_HI    10
`define CTRL_RESET      32'h0000_0000

// status register fields
`define STAT_ROV        0
`define STAT_BTD        1
`define STAT_OVL        2
`define STAT_RPOS       3
`define STAT_RNEG       4
`define STAT_DC800      5
`define STAT_SETTLE     6
`define STAT_MON_HI     7
`define STAT_MON_LO     8

// attenuation coefficients, q1.15
`define ATT_0DB         16'h7FFF
`define ATT_1DB         16'h7215
`define ATT_2P2DB       16'h635B
`define ATT_3P5DB       16'h558C
`define ATT_5DB         16'h47FA

// timing
`define CLK_KHZ         250000
`define RESTORE_MS      1000
`define LPF_SHIFT       3

`endif

// >>> logic/sample_serializer.v
`timescale 1ns/1ps
`default_nettype none
module sample_serializer #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire             bit_en_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] word_i,
  output wire             busy_o,
  output reg              serial_sample_out_o,
  output reg              frame_o
);

  localparam CW = $clog2(WIDTH + 1);
  // bit count of a full word, sized to the down counter
  localparam [CW-1:0] WIDTH_C = WIDTH;

  reg [WIDTH-1:0] shift_q;
  reg [CW-1:0]    left_q;

  assign busy_o = (left_q != {CW{1'b0}});

  // msb-first shifter; frame marks the first bit of each word
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q             <= {WIDTH{1'b0}};
      left_q              <= {CW{1'b0}};
      serial_sample_out_o <= 1'b0;
      frame_o             <= 1'b0;
    end else if (load_i && !busy_o) begin
      shift_q <= word_i;
      left_q  <= WIDTH_C;
    end else if (bit_en_i && busy_o) begin
      serial_sample_out_o <= shift_q[WIDTH-1];
      frame_o             <= (left_q == WIDTH_C);
      shift_q             <= {shift_q[WIDTH-2:0], 1'b0};
      left_q              <= left_q - {{(CW-1){1'b0}}, 1'b1};
    end else if (bit_en_i) begin
      serial_sample_out_o <= 1'b0;
      frame_o             <= 1'b0;
    end
  end

endmodule // sample_serializer
`default_nettype wire

// >>> logic/tone_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "tone_monitor_regs.vh"
module tone_monitor #(
  parameter        SW             = 16,
  parameter [15:0] OVL_LEVEL      = 16'h4000,  // code of 1.1 V peak on the line
  parameter [15:0] RING_THRESH    = 16'h1000,  // ring threshold code
  parameter [31:0] RESTORE_CYCLES = `RESTORE_MS * `CLK_KHZ,
  parameter [7:0]  LINK_DIV       = 8'h04
) (
  input  wire          clk_i,
  input  wire          rstn_i,
  input  wire [7:0]    addr_i,
  input  wire [31:0]   wdata_i,
  input  wire          we_i,
  input  wire          re_i,
  output reg  [31:0]   rdata_o,
  input  wire          line_valid_i,
  input  wire [SW-1:0] line_sample_i,
  input  wire          supply_low_i,
  input  wire          ring_valid_i,
  input  wire [SW-1:0] ring_sense_a_i,
  input  wire [SW-1:0] ring_sense_b_i,
  output reg  [SW-1:0] rx_data_o,
  output reg           rx_valid_o,
  output wire          off_hook_o,
  output wire          dc_800ohm_o,
  output wire          dc_settling_o,
  output wire          mon_hi_en_o,
  output wire          mon_lo_en_o,
  output wire          ring_coupling_reset_o,
  output wire          fullwave_ring_enable_o,
  output wire          serial_sample_out_o,
  output wire          serial_frame_o
);

  reg  [31:0]   ctrl_q;
  reg           rov_q;
  reg           btd_q;
  reg           ovl_q;
  reg           rpos_q;
  reg           rneg_q;
  reg  [31:0]   settle_q;
  reg           tde_prev_q;
  reg  [SW-1:0] lpf_q;
  reg  [SW-1:0] mon_q;
  reg           mon_load_q;
  reg  [7:0]    div_q;
  reg           bit_en_q;
  reg  [31:0]   rd_d;
  wire          ser_busy;

  wire          tde        = ctrl_q[`CTRL_TDE];
  wire          lme        = ctrl_q[`CTRL_LME];
  wire          mode       = ctrl_q[`CTRL_MODE];
  wire [2:0]    gain       = ctrl_q[`CTRL_GAIN_HI:`CTRL_GAIN_LO];
  wire          wr_ctrl    = we_i && (addr_i == `ADDR_CTRL);
  wire          wr_stat    = we_i && (addr_i == `ADDR_STATUS);

  // absolute value of a two's complement sample
  function [SW-1:0] mag;
    input [SW-1:0] v;
    begin
      mag = v[SW-1] ? (~v + {{(SW-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  // attenuation coefficient for the low-power converter input
  function [15:0] att_coef;
    input [2:0] g;
    begin
      case (g)
        3'h0:    att_coef = `ATT_0DB;
        3'h1:    att_coef = `ATT_1DB;
        3'h2:    att_coef = `ATT_2P2DB;
        3'h3:    att_coef = `ATT_3P5DB;
        default: att_coef = `ATT_5DB;
      endcase
    end
  endfunction

  // ring voltage across the two sense inputs
  wire [SW-1:0] ring_diff = ring_sense_a_i - ring_sense_b_i;
  wire          ring_hi   = !ring_diff[SW-1] && (ring_diff > RING_THRESH);
  wire          ring_lo   = ring_diff[SW-1] && (mag(ring_diff) > RING_THRESH);

  // large-signal conditions, only looked at with detection enabled
  wire          ovl_now   = tde && line_valid_i && (mag(line_sample_i) > OVL_LEVEL);
  wire          btd_now   = tde && supply_low_i;

  // low-power path: scaled by the gain field
  wire signed [SW+15:0] att_prod = $signed(ring_diff) * $signed({1'b0, att_coef(gain)});
  wire [SW-1:0]         att_smp  = att_prod[SW+14:15];

  // filter step kept signed so the shift extends the sign
  wire signed [SW-1:0]  lpf_step = $signed(line_sample_i - lpf_q) >>> `LPF_SHIFT;

  // control register
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_i;
    end
  end

  // sticky flags: hardware set wins over a host write of zero
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rov_q <= 1'b0;
      btd_q <= 1'b0;
    end else begin
      if (ovl_now) begin
        rov_q <= 1'b1;
      end else if (wr_stat && !wdata_i[`STAT_ROV]) begin
        rov_q <= 1'b0;
      end
      if (btd_now) begin
        btd_q <= 1'b1;
      end else if (wr_stat && !wdata_i[`STAT_BTD]) begin
        btd_q <= 1'b0;
      end
    end
  end

  // live overload follows each sample
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovl_q <= 1'b0;
    end else if (!tde) begin
      ovl_q <= 1'b0;
    end else if (line_valid_i) begin
      ovl_q <= ovl_now;
    end
  end

  // ring comparators, updated on every ring sample
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rpos_q <= 1'b0;
      rneg_q <= 1'b0;
    end else if (ring_valid_i) begin
      rpos_q <= ring_hi;
      rneg_q <= ring_lo;
    end
  end

  // settle timer runs after tone detection is switched off
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tde_prev_q <= 1'b0;
      settle_q   <= 32'h0000_0000;
    end else begin
      tde_prev_q <= tde;
      if (tde) begin
        settle_q <= 32'h0000_0000;
      end else if (tde_prev_q) begin
        settle_q <= RESTORE_CYCLES;
      end else if (settle_q != 32'h0000_0000) begin
        settle_q <= settle_q - 32'h0000_0001;
      end
    end
  end

  // termination and hook outputs
  assign dc_800ohm_o   = tde && btd_q;
  assign dc_settling_o = (settle_q != 32'h0000_0000);
  assign off_hook_o    = ctrl_q[`CTRL_OFFHOOK];

  // converter selection
  assign mon_hi_en_o = lme && !mode;
  assign mon_lo_en_o = lme && mode;
  assign ring_coupling_reset_o  = ctrl_q[`CTRL_RCR];
  assign fullwave_ring_enable_o = ctrl_q[`CTRL_FWE];

  // receive low-pass filter keeps small tones out of the data
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lpf_q      <= {SW{1'b0}};
      rx_data_o  <= {SW{1'b0}};
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= line_valid_i;
      if (line_valid_i) begin
        lpf_q     <= lpf_q + lpf_step;
        rx_data_o <= lpf_q;
      end
    end
  end

  // monitor sample capture while on-hook monitoring is active
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mon_q      <= {SW{1'b0}};
      mon_load_q <= 1'b0;
    end else begin
      mon_load_q <= 1'b0;
      if (ring_valid_i && lme) begin
        mon_q      <= mode ? att_smp : ring_diff;
        mon_load_q <= 1'b1;
      end
    end
  end

  // link bit-rate divider
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q    <= 8'h00;
      bit_en_q <= 1'b0;
    end else begin
      bit_en_q <= (div_q == 8'h00);
      div_q    <= (div_q == 8'h00) ? (LINK_DIV - 8'h01) : (div_q - 8'h01);
    end
  end

  // samples go out bit-serially; one arriving while busy is dropped
  sample_serializer #(
    .WIDTH (SW)
  ) u_ser (
    .clk_i               (clk_i),
    .rstn_i              (rstn_i),
    .bit_en_i            (bit_en_q),
    .load_i              (mon_load_q),
    .word_i              (mon_q),
    .busy_o              (ser_busy),
    .serial_sample_out_o (serial_sample_out_o),
    .frame_o             (serial_frame_o)
  );

  // read decode
  always @* begin
    rd_d = 32'h0000_0000;
    case (addr_i)
      `ADDR_CTRL: begin
        rd_d = ctrl_q;
      end
      `ADDR_STATUS: begin
        rd_d[`STAT_ROV]    = rov_q;
        rd_d[`STAT_BTD]    = btd_q;
        rd_d[`STAT_OVL]    = ovl_q;
        rd_d[`STAT_RPOS]   = rpos_q;
        rd_d[`STAT_RNEG]   = rneg_q;
        rd_d[`STAT_DC800]  = dc_800ohm_o;
        rd_d[`STAT_SETTLE] = dc_settling_o;
        rd_d[`STAT_MON_HI] = mon_hi_en_o;
        rd_d[`STAT_MON_LO] = mon_lo_en_o;
      end
      `ADDR_SAMPLE: begin
        rd_d[SW-1:0] = mon_q;
      end
      `ADDR_RXDATA: begin
        rd_d[SW-1:0] = rx_data_o;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // read data stands for the single cycle after the strobe
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (re_i) begin
      rdata_o <= rd_d;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule // tone_monitor
`default_nettype wire

// >>> tb/tone_monitor_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tone_monitor_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        we_i,
  input wire logic        re_i,
  input wire logic [31:0] rdata_o,
  input wire logic        line_valid_i,
  input wire logic        rx_valid_o,
  input wire logic        supply_low_i,
  input wire logic        off_hook_o,
  input wire logic        dc_800ohm_o,
  input wire logic        dc_settling_o,
  input wire logic        mon_hi_en_o,
  input wire logic        mon_lo_en_o,
  input wire logic        serial_frame_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // bus, flag, settle and link relations
  property p_rd; !$past(re_i) |-> rdata_o == 32'h0000_0000; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_rx; line_valid_i |=> rx_valid_o; endproperty
  a_rx: assert property (p_rx) else $error("rx valid missing");
  property p_conv; !(mon_hi_en_o && mon_lo_en_o); endproperty
  a_conv: assert property (p_conv) else $error("both converters on");
  property p_hold; dc_800ohm_o && !we_i |=> dc_800ohm_o; endproperty
  a_hold: assert property (p_hold) else $error("800 ohm dropped");
  property p_rise; $rose(dc_800ohm_o) |-> $past(supply_low_i) || $past(we_i); endproperty
  a_rise: assert property (p_rise) else $error("800 ohm without cause");
  property p_settle; $rose(dc_settling_o) |-> dc_settling_o[*8] ##[1:40] !dc_settling_o; endproperty
  a_settle: assert property (p_settle) else $error("settle length wrong");
  property p_hook; $changed(off_hook_o) |-> $past(we_i); endproperty
  a_hook: assert property (p_hook) else $error("hook moved alone");
  property p_frame; $rose(serial_frame_o) |-> serial_frame_o[*4] ##1 !serial_frame_o; endproperty
  a_frame: assert property (p_frame) else $error("frame width wrong");
  c_dc: cover property (dc_800ohm_o);
  c_st: cover property ($rose(dc_settling_o));
  c_fr: cover property ($rose(serial_frame_o));
endmodule // tone_monitor_checker
bind tone_monitor tone_monitor_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .line_valid_i(line_valid_i), .rx_valid_o(rx_valid_o),
  .supply_low_i(supply_low_i), .off_hook_o(off_hook_o), .dc_800ohm_o(dc_800ohm_o),
  .dc_settling_o(dc_settling_o), .mon_hi_en_o(mon_hi_en_o), .mon_lo_en_o(mon_lo_en_o),
  .serial_frame_o(serial_frame_o));
`default_nettype wire

// >>> tb/sample_sink.sv
`timescale 1ns/1ps
`default_nettype none
module sample_sink #(
  parameter DIV = 4
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  input  wire logic   sdata_i,
  input  wire logic   frame_i,
  output logic [15:0] word_o,
  output logic        valid_o
);
  logic [7:0] cnt_q;
  logic [4:0] n_q;
  // word starts at the frame bit, each bit taken mid-cell, msb first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 8'h00;
      n_q <= 5'h10;
      valid_o <= 1'b0;
      word_o <= 16'h0000;
    end else begin
      valid_o <= 1'b0;
      if (n_q == 5'h10) begin
        cnt_q <= 8'h01;
        if (frame_i) n_q <= 5'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q % DIV == DIV / 2) begin
          word_o <= {word_o[14:0], sdata_i};
          n_q <= n_q + 5'h01;
          valid_o <= (n_q == 5'h0F);
        end
      end
    end
  end
endmodule // sample_sink
`default_nettype wire

// >>> tb/tb_billing_tone_and_onhook_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "tone_monitor_regs.vh"
module tb_billing_tone_and_onhook_monitor;
  logic        clk_i, rstn_i, we_i, re_i, line_valid_i, supply_low_i, ring_valid_i, wv;
  logic        rx_valid_o, off_hook_o, dc_800ohm_o, dc_settling_o, mon_hi_en_o, mon_lo_en_o;
  logic        rcr_o, fw_o, sdo_o, frame_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, got, exp_w;
  logic [15:0] line_sample_i, ring_a, ring_b, rx_data_o, word, raw;
  logic signed [15:0] d;
  integer      error_cnt, n_tests, seed, i, k;
  tone_monitor #(.RESTORE_CYCLES(32'd20)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .line_valid_i(line_valid_i),
    .line_sample_i(line_sample_i), .supply_low_i(supply_low_i), .ring_valid_i(ring_valid_i),
    .ring_sense_a_i(ring_a), .ring_sense_b_i(ring_b), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .off_hook_o(off_hook_o), .dc_800ohm_o(dc_800ohm_o),
    .dc_settling_o(dc_settling_o), .mon_hi_en_o(mon_hi_en_o), .mon_lo_en_o(mon_lo_en_o),
    .ring_coupling_reset_o(rcr_o), .fullwave_ring_enable_o(fw_o),
    .serial_sample_out_o(sdo_o), .serial_frame_o(frame_o));
  sample_sink u_sink (.clk_i(clk_i), .rstn_i(rstn_i), .sdata_i(sdo_o), .frame_i(frame_o),
    .word_o(word), .valid_o(wv));
  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task chk(input [31:0] g, input [31:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input [7:0] a);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 got = rdata_o;
    @(posedge clk_i);
  endtask
  task samp(input [15:0] x);
    line_sample_i <= x;
    line_valid_i <= 1'b1;
    @(posedge clk_i);
    line_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task ring(input [15:0] a, input [15:0] b);
    ring_a <= a;
    ring_b <= b;
    ring_valid_i <= 1'b1;
    @(posedge clk_i);
    ring_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // expected low-power converter word: diff scaled by the gain coefficient
  function [15:0] att(input [15:0] v, input [2:0] g);
    logic [15:0] c;
    logic signed [31:0] p;
    case (g)
      3'd0: c = `ATT_0DB;
      3'd1: c = `ATT_1DB;
      3'd2: c = `ATT_2P2DB;
      3'd3: c = `ATT_3P5DB;
      default: c = `ATT_5DB;
    endcase
    p = $signed(v) * $signed({1'b0, c});
    att = p[30:15];
  endfunction
  // main sequence
  initial begin
    seed = 29041;
    error_cnt = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    {we_i, re_i, line_valid_i, supply_low_i, ring_valid_i} = 5'h00;
    {addr_i, wdata_i, line_sample_i, ring_a, ring_b} = 88'h0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(`ADDR_CTRL);
    chk(got, 32'h0000_0000);
    rd(8'h10);
    chk(got, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      exp_w = ($random(seed) & 32'hFFFF_FFC0) | (i << 1);
      wr(`ADDR_CTRL, exp_w);
      chk({mon_lo_en_o, mon_hi_en_o}, {i[1] & i[0], ~i[1] & i[0]});
      rd(`ADDR_CTRL);
      chk(got, exp_w);
    end
    wr(`ADDR_CTRL, 32'h0000_0018);
    chk({rcr_o, fw_o}, 2'b11);
    for (i = 0; i < 7; i = i + 1) begin
      wr(`ADDR_CTRL, (i < 6) ? (32'h0000_001E | (i << 8)) : 32'h0000_0002);
      ring($random(seed) % 4096, $random(seed) % 4096);
      for (k = 0; k < 300 && wv !== 1'b1; k = k + 1) @(negedge clk_i);
      if (k == 300) begin
        chk(32'h0000_0000, 32'h0000_0001);
        close_out;
      end
      @(posedge clk_i);
      raw = ring_a - ring_b;
      chk(word, (i < 6) ? att(ring_a - ring_b, i) : raw);
    end
    rd(`ADDR_SAMPLE);
    chk(got, {16'h0000, raw});
    wr(`ADDR_CTRL, 32'h0000_0000);
    chk({rcr_o, fw_o, mon_lo_en_o, mon_hi_en_o}, 4'h0);
    for (i = 0; i < 8; i = i + 1) begin
      d = (i < 4) ? (i[1] ? -16'sh1000 - i[0] : 16'sh1000 + i[0]) : $random(seed) % 8192;
      ring(d, 16'h0000);
      rd(`ADDR_STATUS);
      chk(got[4:3], {d < -16'sh1000, d > 16'sh1000});
    end
    wr(`ADDR_CTRL, 32'h0000_0020);
    supply_low_i <= 1'b1;
    samp(16'h7000);
    supply_low_i <= 1'b0;
    rd(`ADDR_STATUS);
    chk(got[2:0], 3'b000);
    wr(`ADDR_CTRL, 32'h0000_0021);
    samp(16'h4000);
    rd(`ADDR_STATUS);
    chk(got[2:0], 3'b000);
    samp(16'hBFFF);
    rd(`ADDR_STATUS);
    chk(got[2:0], 3'b101);
    samp(16'h0100);
    rd(`ADDR_STATUS);
    chk(got[2:0], 3'b001);
    supply_low_i <= 1'b1;
    wr(`ADDR_STATUS, 32'h0000_0000);
    supply_low_i <= 1'b0;
    rd(`ADDR_STATUS);
    chk({dc_800ohm_o, got[1:0]}, 3'b110);
    chk(got[8:5], 4'h1);
    wr(`ADDR_STATUS, 32'h0000_0003);
    rd(`ADDR_STATUS);
    chk(got[1:0], 2'b10);
    wr(`ADDR_CTRL, 32'h0000_0020);
    for (k = 0; k < 10 && dc_settling_o !== 1'b1; k = k + 1) @(negedge clk_i);
    for (k = 0; k < 60 && dc_settling_o === 1'b1; k = k + 1) @(negedge clk_i);
    chk({k > 17 && k < 23, dc_800ohm_o, off_hook_o}, 3'b101);
    @(posedge clk_i);
    wr(`ADDR_STATUS, 32'h0000_0000);
    rd(`ADDR_STATUS);
    chk(got[1:0], 2'b00);
    wr(`ADDR_CTRL, 32'h0000_0021);
    rd(`ADDR_STATUS);
    chk(got[2:0], 3'b000);
    for (i = 0; i < 16; i = i + 1) samp(i[0] ? 16'h3000 : 16'hD000);
    d = rx_data_o;
    chk(d < 16'sh0800 && d > -16'sh0800, 1'b1);
    close_out;
  end
endmodule // tb_billing_tone_and_onhook_monitor
`default_nettype wire
